// *** src/adc_clock_regs.vh ***
// constants for the converter clock, mode and conversion-timing control
// Overview of operation
// - modulator rate: clock /8, /4, /40, /8
// - clock per word: 512, 256, 2560, 512
// - mode pin low fast, high low-power
// - mode pin watched continuously, no reset needed
// - SPI: ready_n high until settled data
// - frame-sync: data held zero until settled
// - output code saturates at 7FFF/8000
// - output fully settled after 76 words
// - all channels from one clock, rate scales
// - decimation filter is linear phase
// - decimation ratio fixed at 64
// - results are 16-bit two's complement
// - format codes 0-2 SPI, 3-5 frame-sync
`ifndef ADC_CLOCK_REGS_VH
`define ADC_CLOCK_REGS_VH

// modulator clock dividers per mode and divide pin
`define MOD_DIV_FAST_HI   6'h08
`define MOD_DIV_FAST_LO   6'h04
`define MOD_DIV_SLOW_HI   6'h28
`define MOD_DIV_SLOW_LO   6'h08
`define MOD_DIV_W         6

// oversampling ratio and its counter width
`define DECIM_RATIO       7'h40
`define DECIM_LAST        6'h3F
`define DECIM_W           6

// settling: words of little change, words until fully settled
`define SETTLE_QUIET      7'h1E
`define SETTLE_WORDS      7'h4C
`define SETTLE_W          7

// output code limits, word width
`define CODE_MAX          16'h7FFF
`define CODE_MIN          16'h8000
`define WORD_W            16

// format select decode: frame-sync code range
`define FMT_FS_FIRST      3'h3
`define FMT_FS_LAST       3'h5

// mode pin levels
`define MODE_FAST         1'h0
`define MODE_SLOW         1'h1

// supported master clock range, in kHz
`define CLK_MIN_KHZ       100
`define CLK_MAX_KHZ       27000

`endif

// *** src/decim_chan.v ***
// one channel of the linear-phase decimation filter
`timescale 1ns/1ps
`include "adc_clock_regs.vh"

module decim_chan (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 clkEn,
  input  wire                 restart,
  input  wire                 modTick,
  input  wire                 wordTick,
  input  wire                 modBit,
  output reg  [`WORD_W-1:0]   wordNext
);

  reg  [6:0] onesCnt_q;   // ones seen in the current 64-sample block
  reg  [6:0] prevCnt_q;   // previous block count, second tap
  wire [6:0] blockCnt;
  wire [7:0] pairSum;

  // saturate a scaled signed value into the 16-bit code range
  function [`WORD_W-1:0] satCode;
    input signed [17:0] v;
    begin
      if (v > $signed({2'b00, `CODE_MAX}))
        satCode = `CODE_MAX;
      else if (v < -$signed(18'h08000))
        satCode = `CODE_MIN;
      else
        satCode = v[`WORD_W-1:0];
    end
  endfunction

  assign blockCnt = onesCnt_q + {6'h00, modBit};
  assign pairSum  = {1'b0, blockCnt} + {1'b0, prevCnt_q};

  // two equal taps of boxcars: symmetric response, constant delay
  // (sum - 64) * 512: a sum of 64 is mid-scale, all ones or all zeros hit the limits
  always @* begin
    wordNext = satCode($signed({1'b0, pairSum, 9'h000}) - $signed(18'h08000));
  end

  // count ones across exactly one decimation block
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      onesCnt_q <= 7'h00;
      prevCnt_q <= `DECIM_RATIO >> 1;
    end else if (clkEn) begin
      if (restart) begin
        onesCnt_q <= 7'h00;
        prevCnt_q <= `DECIM_RATIO >> 1;
      end else if (wordTick) begin
        onesCnt_q <= 7'h00;
        prevCnt_q <= blockCnt;
      end else if (modTick) begin
        onesCnt_q <= blockCnt;
      end
    end
  end

endmodule // decim_chan

// *** src/adc_clock_mode_control.v ***
// clock, mode and conversion-timing control of the multichannel converter
`timescale 1ns/1ps
`include "adc_clock_regs.vh"

module adc_clock_mode_control #(
  parameter NUM_CH = 8
) (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      clkEn,
  input  wire                      modeSelect,
  input  wire                      clockDivideSelect,
  input  wire [2:0]                formatSelect,
  input  wire [NUM_CH-1:0]         modBits,
  output wire                      modulatorRate,
  output wire                      wordTick,
  output wire                      conversionReadyN,
  output wire [NUM_CH*`WORD_W-1:0] convData,
  output wire                      dataValid,
  output wire                      lowPowerActive,
  output wire                      frameSyncActive,
  output wire                      filterQuiet
);

  // controller states, one-hot
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_SETTLE = 3'h2;
  localparam [2:0] ST_RUN    = 3'h4;

  // pin bundle layout: {format[2:0], divide, mode}
  localparam PIN_W = 5;

  reg  [PIN_W-1:0]          pinSync1_q;
  reg  [PIN_W-1:0]          pinSync2_q;
  reg  [PIN_W-1:0]          pinSync3_q;
  reg  [PIN_W-1:0]          pinLvl_q;
  reg  [PIN_W-1:0]          pinLvl_d;
  wire [PIN_W-1:0]          pinRaw;
  wire [PIN_W-1:0]          pinAgree;

  reg  [2:0]                state_q;
  reg  [2:0]                state_d;
  reg                       restart;

  reg  [`MOD_DIV_W-1:0]     modCnt_q;
  reg  [`MOD_DIV_W-1:0]     modCnt_d;
  wire [`MOD_DIV_W-1:0]     modDiv;
  wire                      modTick;

  reg  [`DECIM_W-1:0]       wordCnt_q;
  reg  [`DECIM_W-1:0]       wordCnt_d;

  reg  [`SETTLE_W-1:0]      settleCnt_q;
  reg  [`SETTLE_W-1:0]      settleCnt_d;
  wire                      settleDone;

  reg                       readyN_q;
  reg                       readyN_d;
  reg  [NUM_CH*`WORD_W-1:0] data_q;
  reg  [NUM_CH*`WORD_W-1:0] data_d;
  wire [NUM_CH*`WORD_W-1:0] chanWords;

  wire                      modeLvl;
  wire                      divLvl;
  wire [2:0]                fmtLvl;
  wire                      fsFormat;
  wire                      cfgChange;

  // modulator divider for a given mode and divide pin
  function [`MOD_DIV_W-1:0] modDivFor;
    input lowPower;
    input divHigh;
    begin
      case ({lowPower, divHigh})
        2'b01:   modDivFor = `MOD_DIV_FAST_HI;
        2'b00:   modDivFor = `MOD_DIV_FAST_LO;
        2'b11:   modDivFor = `MOD_DIV_SLOW_HI;
        2'b10:   modDivFor = `MOD_DIV_SLOW_LO;
        default: modDivFor = `MOD_DIV_FAST_HI;
      endcase
    end
  endfunction

  // true when a format code selects frame-sync framing
  function isFrameSync;
    input [2:0] code;
    begin
      isFrameSync = (code >= `FMT_FS_FIRST) && (code <= `FMT_FS_LAST);
    end
  endfunction

  assign pinRaw = {formatSelect, clockDivideSelect, modeSelect};

  // pins are asynchronous: three flops, second and third must agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinSync1_q <= {PIN_W{1'b0}};
      pinSync2_q <= {PIN_W{1'b0}};
      pinSync3_q <= {PIN_W{1'b0}};
    end else if (clkEn) begin
      pinSync1_q <= pinRaw;
      pinSync2_q <= pinSync1_q;
      pinSync3_q <= pinSync2_q;
    end
  end

  assign pinAgree = ~(pinSync2_q ^ pinSync3_q);

  // accepted level moves only where both late stages agree
  always @* begin
    pinLvl_d = (pinSync2_q & pinAgree) | (pinLvl_q & ~pinAgree);
  end

  // levels are sampled on every enabled cycle, in every controller state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pinLvl_q <= {PIN_W{1'b0}};
    end else if (clkEn) begin
      pinLvl_q <= pinLvl_d;
    end
  end

  assign modeLvl   = pinLvl_q[0];
  assign divLvl    = pinLvl_q[1];
  assign fmtLvl    = pinLvl_q[4:2];
  assign fsFormat  = isFrameSync(fmtLvl);
  // a new divide setting also moves the modulator rate, so it restarts too
  assign cfgChange = (pinLvl_d[1:0] != pinLvl_q[1:0]);

  // controller: idle after reset, then settle, then run
  always @* begin
    state_d = state_q;
    restart = 1'b0;
    case (state_q)
      ST_IDLE: begin
        restart = 1'b1;
        state_d = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (cfgChange) begin
          restart = 1'b1;
        end else if (settleDone) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cfgChange) begin
          restart = 1'b1;
          state_d = ST_SETTLE;
        end
      end
      default: begin
        restart = 1'b1;
        state_d = ST_SETTLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // the divider is picked from levels already accepted
  assign modDiv  = modDivFor(modeLvl, divLvl);
  assign modTick = (modCnt_q == modDiv - 6'h01) && !restart;

  // modulator divider; one shared counter keeps channels in step
  always @* begin
    if (restart)
      modCnt_d = {`MOD_DIV_W{1'b0}};
    else if (modTick)
      modCnt_d = {`MOD_DIV_W{1'b0}};
    else
      modCnt_d = modCnt_q + 6'h01;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      modCnt_q <= {`MOD_DIV_W{1'b0}};
    end else if (clkEn) begin
      modCnt_q <= modCnt_d;
    end
  end

  // 64 modulator samples per output word in every mode
  assign wordTick = modTick && (wordCnt_q == `DECIM_LAST);

  always @* begin
    if (restart)
      wordCnt_d = {`DECIM_W{1'b0}};
    else if (wordTick)
      wordCnt_d = {`DECIM_W{1'b0}};
    else if (modTick)
      wordCnt_d = wordCnt_q + 6'h01;
    else
      wordCnt_d = wordCnt_q;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wordCnt_q <= {`DECIM_W{1'b0}};
    end else if (clkEn) begin
      wordCnt_q <= wordCnt_d;
    end
  end

  // settling count in output words; saturates once settled
  assign settleDone = wordTick && (settleCnt_q == `SETTLE_WORDS - 7'h01);

  always @* begin
    if (restart)
      settleCnt_d = {`SETTLE_W{1'b0}};
    else if (wordTick && settleCnt_q != `SETTLE_WORDS)
      settleCnt_d = settleCnt_q + 7'h01;
    else
      settleCnt_d = settleCnt_q;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      settleCnt_q <= {`SETTLE_W{1'b0}};
    end else if (clkEn) begin
      settleCnt_q <= settleCnt_d;
    end
  end

  // one filter per channel, all fed by the same ticks
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : gChan
      decim_chan uChan (
        .clk      (clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .restart  (restart),
        .modTick  (modTick),
        .wordTick (wordTick),
        .modBit   (modBits[ch]),
        .wordNext (chanWords[ch*`WORD_W +: `WORD_W])
      );
    end
  endgenerate

  // data words: zero until settled, so frame-sync lines stay low
  always @* begin
    data_d = data_q;
    if (restart)
      data_d = {NUM_CH*`WORD_W{1'b0}};
    else if (wordTick && (settleDone || state_q == ST_RUN))
      data_d = chanWords;
    else if (wordTick)
      data_d = {NUM_CH*`WORD_W{1'b0}};
  end

  // ready: high while settling and in frame-sync formats; otherwise low for one modulator period per word
  always @* begin
    readyN_d = readyN_q;
    if (restart || fsFormat)
      readyN_d = 1'b1;
    else if (wordTick && (settleDone || state_q == ST_RUN))
      readyN_d = 1'b0;
    else if (modTick)
      readyN_d = 1'b1;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q   <= {NUM_CH*`WORD_W{1'b0}};
      readyN_q <= 1'b1;
    end else if (clkEn) begin
      data_q   <= data_d;
      readyN_q <= readyN_d;
    end
  end

  // status levels for the serial port and the host
  assign modulatorRate    = modTick;
  assign conversionReadyN = readyN_q;
  assign convData         = data_q;
  assign dataValid        = (state_q == ST_RUN);
  assign lowPowerActive   = (modeLvl == `MODE_SLOW);
  assign frameSyncActive  = fsFormat;
  // early words move little; the flag lets the host see that window
  assign filterQuiet      = (state_q == ST_SETTLE) && (settleCnt_q < `SETTLE_QUIET);

endmodule // adc_clock_mode_control

// *** sim/adc_clock_mode_control_assertions.sv ***
// concurrent checks on the ports of the converter clock and mode control
`timescale 1ns/1ps
module adc_clock_mode_control_assertions #(
  parameter NUM_CH = 8
) (
  input wire                      clk,
  input wire                      rst,
  input wire                      clkEn,
  input wire                      modeSelect,
  input wire                      clockDivideSelect,
  input wire [2:0]                formatSelect,
  input wire [NUM_CH-1:0]         modBits,
  input wire                      modulatorRate,
  input wire                      wordTick,
  input wire                      conversionReadyN,
  input wire [NUM_CH*16-1:0]      convData,
  input wire                      dataValid,
  input wire                      lowPowerActive,
  input wire                      frameSyncActive,
  input wire                      filterQuiet
);
  logic [5:0] gapQ;
  logic [5:0] modCntQ;

  // gap between modulator pulses and pulses per word, frozen with the design
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapQ <= 6'h00;
      modCntQ <= 6'h00;
    end else if (clkEn) begin
      gapQ <= modulatorRate ? 6'h00 : gapQ + 6'h01;
      if (wordTick)
        modCntQ <= 6'h00;
      else if (modulatorRate)
        modCntQ <= modCntQ + 6'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // periods are only exact once settled, since a restart cuts a period short
  AST_MOD_GAP: assert property (modulatorRate && clkEn && dataValid && $past(dataValid) |->
    (lowPowerActive ? (gapQ == 6'h07 || gapQ == 6'h27) : (gapQ == 6'h03 || gapQ == 6'h07)))
    else $error("modulator pulse spacing wrong");
  AST_WORD_GAP: assert property (wordTick && clkEn && dataValid && $past(dataValid) |->
    modCntQ == 6'h3F) else $error("word tick not after 64 modulator pulses");
  AST_WORD_IS_MOD: assert property (wordTick |-> modulatorRate)
    else $error("word tick off a modulator pulse");
  AST_READY_AT_WORD: assert property ($fell(conversionReadyN) |-> $past(wordTick))
    else $error("ready fell away from a word tick");
  AST_READY_ONE_PERIOD: assert property (!conversionReadyN && modulatorRate && clkEn
    |=> conversionReadyN) else $error("ready low past one modulator period");
  // ready is registered, so it answers the framing of the cycle before
  AST_READY_SPI_ONLY: assert property (!conversionReadyN |-> !$past(frameSyncActive))
    else $error("ready low in frame-sync framing");
  AST_DATA_HELD_ZERO: assert property (!dataValid && !$past(dataValid) && !$past(wordTick)
    |-> convData == '0) else $error("data not zero while settling");
  AST_QUIET_UNSETTLED: assert property (filterQuiet |-> !dataValid)
    else $error("quiet flag while settled");
  AST_MODE_RESTARTS: assert property ($changed(lowPowerActive) |-> ##[0:3] !dataValid)
    else $error("mode change kept data valid");

  // main scenarios reached
  cover property ($fell(conversionReadyN));
  cover property (frameSyncActive && $rose(dataValid));
  cover property ($changed(lowPowerActive));
endmodule // adc_clock_mode_control_assertions

// *** sim/host_reader.sv ***
// host-side model that picks up channel 0 words as a serial reader would
`timescale 1ns/1ps
module host_reader #(
  parameter NUM_CH = 8
) (
  input  wire  logic                 clk,
  input  wire  logic                 rst,
  input  wire  logic                 hostClear,
  input  wire  logic [2:0]           formatSelect,
  input  wire  logic                 conversionReadyN,
  input  wire  logic [NUM_CH*16-1:0] convData,
  output logic [15:0]                hostWord,
  output logic                       hostGot
);
  logic frameSync;
  logic readyLastQ;

  assign frameSync = (formatSelect >= 3'h3) && (formatSelect <= 3'h5);

  // spi waits for ready to fall; frame-sync takes the first one bit as data start
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hostWord <= 16'h0000;
      hostGot <= 1'b0;
      readyLastQ <= 1'b1;
    end else if (hostClear) begin
      hostGot <= 1'b0;
    end else begin
      readyLastQ <= conversionReadyN;
      if (!hostGot && !frameSync && readyLastQ && !conversionReadyN) begin
        hostWord <= convData[15:0];
        hostGot <= 1'b1;
      end else if (!hostGot && frameSync && |convData[15:0]) begin
        hostWord <= convData[15:0];
        hostGot <= 1'b1;
      end
    end
  end
endmodule // host_reader

// *** sim/tb_top.sv ***
// self-checking bench for the converter clock and mode control
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic mode; logic div; int modPer; int wordPer;} row_t;
  logic         clk;
  logic         rst;
  logic         clkEn;
  logic         modeSelect;
  logic         clockDivideSelect;
  logic [2:0]   formatSelect;
  logic [7:0]   modBits;
  logic         hostClear;
  wire          modulatorRate;
  wire          wordTick;
  wire          conversionReadyN;
  wire  [127:0] convData;
  wire          dataValid;
  wire          lowPowerActive;
  wire          frameSyncActive;
  wire          filterQuiet;
  wire  [15:0]  hostWord;
  int           n_fail;
  int           compares;
  int           w, lo, n, k;
  logic         qe, ql;
  row_t rows [4] = '{'{1'b0, 1'b1, 8, 512}, '{1'b0, 1'b0, 4, 256},
                     '{1'b1, 1'b0, 8, 512}, '{1'b1, 1'b1, 40, 2560}};

  adc_clock_mode_control #(.NUM_CH(8)) u_adc_clock_mode_control (
    .clk(clk), .rst(rst), .clkEn(clkEn), .modeSelect(modeSelect),
    .clockDivideSelect(clockDivideSelect), .formatSelect(formatSelect), .modBits(modBits),
    .modulatorRate(modulatorRate), .wordTick(wordTick), .conversionReadyN(conversionReadyN),
    .convData(convData), .dataValid(dataValid), .lowPowerActive(lowPowerActive),
    .frameSyncActive(frameSyncActive), .filterQuiet(filterQuiet));

  host_reader #(.NUM_CH(8)) u_host_reader (
    .clk(clk), .rst(rst), .hostClear(hostClear), .formatSelect(formatSelect),
    .conversionReadyN(conversionReadyN), .convData(convData), .hostWord(hostWord),
    .hostGot());

  // one fixed bench clock; the rate ratios, not the absolute frequency, are checked
  always #10 clk = ~clk;

  task automatic cmpNum(input logic [31:0] exp, input logic [31:0] act);
    compares++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task automatic cmpData(input logic [127:0] exp, input logic [127:0] act);
    compares++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  // cycles between two pulses of the modulator (0) or word (1) tick
  task automatic period(input int which, output int cnt);
    int j;
    cnt = 0;
    for (j = 0; j < 6000 && !(which ? wordTick : modulatorRate); j++) @(negedge clk);
    @(negedge clk);
    while (!(which ? wordTick : modulatorRate) && cnt < 6000) begin
      cnt++;
      @(negedge clk);
    end
    cnt++;
  endtask

  // words until ready (spi) or valid (frame-sync), then cycles ready stays low
  task automatic settle(input logic fs, output int words, output int low,
                        output logic qEarly, output logic qLate);
    int j;
    words = 0;
    low = 0;
    for (j = 0; j < 25000; j++) begin
      @(negedge clk);
      if (fs ? dataValid : !conversionReadyN) break;
      if (wordTick) words++;
      if (words == 10) qEarly = filterQuiet;
      if (words == 40) qLate = filterQuiet;
    end
    while (!conversionReadyN && low < 100) begin
      low++;
      @(negedge clk);
    end
  endtask

  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, about twice the expected run
  initial begin
    #1800000;
    n_fail++;
    conclude();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; clkEn = 1'b1; modeSelect = 1'b0; clockDivideSelect = 1'b0;
    formatSelect = 3'h0; modBits = 8'hFF; hostClear = 1'b0; n_fail = 0; compares = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle(1'b0, w, lo, qe, ql);
    cmpNum(76, w);
    cmpNum(1, qe);
    cmpNum(0, ql);
    cmpNum(4, lo);
    cmpData({8{16'h7FFF}}, convData);
    cmpNum(16'h7FFF, hostWord);
    // every mode and divide pairing, each change restarting the filter
    foreach (rows[i]) begin
      @(posedge clk);
      modeSelect <= rows[i].mode;
      clockDivideSelect <= rows[i].div;
      repeat (8) @(negedge clk);
      cmpNum(rows[i].mode, lowPowerActive);
      cmpNum(0, dataValid);
      cmpData('0, convData);
      period(0, n);
      cmpNum(rows[i].modPer, n);
      period(1, n);
      cmpNum(rows[i].wordPer, n);
    end
    // frame-sync settle at negative full scale, no reset in between
    @(posedge clk);
    modBits <= 8'h00;
    formatSelect <= 3'h3;
    modeSelect <= 1'b0;
    clockDivideSelect <= 1'b0;
    hostClear <= 1'b1;
    @(posedge clk);
    hostClear <= 1'b0;
    for (k = 0; k < 20 && lowPowerActive !== 1'b0; k++) @(negedge clk);
    repeat (2) @(negedge clk);
    settle(1'b1, w, lo, qe, ql);
    cmpNum(76, w);
    cmpNum(0, lo);
    cmpData({8{16'h8000}}, convData);
    // the host only sees the new word at the next rising edge
    @(negedge clk);
    cmpNum(16'h8000, hostWord);
    // format codes switch framing without a restart
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      formatSelect <= k[2:0];
      repeat (6) @(negedge clk);
      cmpNum(k >= 3 && k <= 5, frameSyncActive);
      cmpNum(1, dataValid);
    end
    // mode change while settled must withdraw valid data
    @(posedge clk);
    modeSelect <= 1'b1;
    repeat (8) @(negedge clk);
    cmpNum(1, lowPowerActive);
    cmpNum(0, dataValid);
    cmpData('0, convData);
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(negedge clk);
    cmpNum(1, conversionReadyN);
    cmpNum(0, dataValid);
    cmpData('0, convData);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    cmpNum(1, filterQuiet);
    cmpNum(0, dataValid);
    cmpNum(1, conversionReadyN);
    conclude();
  end
endmodule // tb_top

bind adc_clock_mode_control adc_clock_mode_control_assertions #(.NUM_CH(NUM_CH))
  u_adc_clock_mode_control_assertions (.clk(clk), .rst(rst), .clkEn(clkEn),
  .modeSelect(modeSelect), .clockDivideSelect(clockDivideSelect),
  .formatSelect(formatSelect), .modBits(modBits), .modulatorRate(modulatorRate),
  .wordTick(wordTick), .conversionReadyN(conversionReadyN), .convData(convData),
  .dataValid(dataValid), .lowPowerActive(lowPowerActive),
  .frameSyncActive(frameSyncActive), .filterQuiet(filterQuiet));
